// File: core/dpb_core.v
// Instruction cycle sequencer, bus request/grant and program memory interface
//
// Overview of operation
// - Each instruction cycle runs eight states, from a four-times master clock.
// - State 8 is idle; any suspension stops the processor there.
// - Cycle clock output runs at instruction rate, locked to the states.
// - Cycle clock falls between states 3 and 4, rises between 7 and 8.
// - Reset, halt, bus request, acknowledge and interrupts are resynchronised first.
// - Halt is sampled at end of state 3, interrupts at end of 7.
// - Missed inputs are seen next cycle; hold them one full cycle.
// - Bus request recognised at end of state 3; stop in that state 8.
// - Grant asserted four master clocks after recognising the request.
// - While granted outside reset, every memory interface line floats.
// - A bus hold leaves processor state intact; resume exactly where stopped.
// - A request may be serviced between two cycles of a data access.
// - Four master clocks after request release, drop grant and resume at state 1.
// - During reset, grant follows request with only propagation delay.
// - Request while halted or trapped is granted normally; processor stays halted.
// - Program address is 14 bits, program data is 24 bits bidirectional.
// - Select asserted on every program fetch cycle, off when halted or released.
// - Read strobe acts as output enable, write strobe as write strobe.
// - Data-space flag timed like the address, set on data transfers.
// - Read: address, flag, select, then strobe, capture, strobe off.
// - Write: address with select, then data, then strobe, then strobe off.
`timescale 1ns/1ps
`default_nettype none
`include "dpb_consts.vh"

module dpb_core #(
    parameter AW = `DPB_ADDR_W,
    parameter DW = `DPB_DATA_W,
    parameter IW = `DPB_IRQ_W
) (
    input  wire          clk,                  // Master clock, one state per rising edge
    input  wire          rst_n,                // Asynchronous reset pin, active low
    input  wire          halt_n,               // Halt pin, active low, asynchronous
    input  wire          bus_request_n,        // Bus request pin, active low
    output wire          bus_grant_n,          // Bus grant pin, active low
    input  wire          data_mem_acknowledge, // Data memory acknowledge pin
    input  wire [IW-1:0] interrupt_requests,   // Interrupt request pins, active low
    output reg           cycle_clock_out,      // Instruction-rate clock
    output reg  [7:0]    cycle_state,          // One-hot state 1..8
    output reg  [AW-1:0] prog_addr_bus,        // Program address
    output reg           prog_addr_oe,         // Drive enable for address lines
    output reg           prog_data_space_flag, // Data-space flag
    output reg           prog_mem_select_n,    // Program memory select
    output reg           prog_read_strobe_n,   // Program read strobe
    output reg           prog_write_strobe_n,  // Program write strobe
    output reg           prog_ctrl_oe,         // Drive enable for flag, select, strobes
    input  wire [DW-1:0] prog_data_in,         // Program data bus, pin level
    output reg  [DW-1:0] prog_data_out,        // Program data bus, driven value
    output reg           prog_data_oe,         // Drive enable for program data bus
    output reg           data_if_oe,           // Drive enable for data memory lines
    output reg           ack_sync,             // Synchronised acknowledge
    output reg  [IW-1:0] irq_latched,          // Interrupt levels caught at end of state 7
    output reg           halted,               // Stopped in state 8
    output reg           trap_active,          // Trap signal towards the pin
    input  wire          trap_in,              // Trap instruction executing this cycle
    input  wire          acc_valid,            // Access request for next cycle
    input  wire          acc_write,            // Access is a write
    input  wire          acc_data_space,       // Access is a data transfer
    input  wire [AW-1:0] acc_addr,             // Access address
    input  wire [DW-1:0] acc_wdata,            // Write data
    output reg           acc_taken,            // Pulse: access taken for next cycle
    output reg  [DW-1:0] rd_data,              // Captured read data
    output reg           rd_valid              // Pulse: read data captured
);
    localparam [3:0] BUS_RUN     = 4'h1;
    localparam [3:0] BUS_WAITG   = 4'h2;
    localparam [3:0] BUS_GRANT   = 4'h4;
    localparam [3:0] BUS_RETURN  = 4'h8;
    localparam [`DPB_CNT_W-1:0] HANDOVER_LAST = `DPB_HANDOVER_CYC - 1;

    // Reset release through two flops
    reg rst_meta_reg;
    reg rst_sync_reg;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end
    wire rs_n = rst_sync_reg;

    wire          halt_s;
    wire          br_s;
    wire          ack_s;
    wire [IW-1:0] irq_s;
    dpb_sync2 #(
        .W       (IW + 3),
        .RST_VAL ({(IW + 3){1'b1}})
    ) u_sync (
        .clk      (clk),
        .rst_n    (rs_n),
        .async_in ({halt_n, bus_request_n, data_mem_acknowledge, interrupt_requests}),
        .sync_out ({halt_s, br_s, ack_s, irq_s})
    );

    wire br_req   = ~br_s;
    wire halt_req = ~halt_s;

    reg [7:0]            phase_reg;
    reg [7:0]            phase_next;
    reg                  frozen_reg;
    reg [3:0]            bus_reg;
    reg [3:0]            bus_next;
    reg [`DPB_CNT_W-1:0] cnt_reg;
    reg [`DPB_CNT_W-1:0] cnt_next;
    reg                  grant_n_reg;
    reg                  halt_pend_reg;
    reg                  halt_defer_reg;
    reg                  trapped_reg;
    reg                  cur_valid_reg;
    reg                  cur_write_reg;
    reg                  cur_data_reg;

    wire running = ~frozen_reg;
    wire end_s3  = phase_reg[`DPB_S3_BIT] & running;
    wire end_s7  = phase_reg[`DPB_S7_BIT];
    wire end_s8  = phase_reg[`DPB_S8_BIT];
    wire bus_own = (bus_reg == BUS_RUN);

    // Stop at state 8 for a bus hold, a halt or a trap
    wire halt_stop = halt_pend_reg & ~(cur_data_reg & ~halt_defer_reg);
    wire stop_now  = end_s8 & (~bus_own | (bus_reg == BUS_RUN & bus_next != BUS_RUN)
                     | halt_stop | trapped_reg);
    wire stay      = frozen_reg & (~bus_own | halt_req | trapped_reg);
    wire freeze_next = stop_now | stay;

    always @* begin
        if (freeze_next) begin
            phase_next = `DPB_PHASE_S8;
        end else begin
            phase_next = {phase_reg[6:0], phase_reg[7]};
        end
    end

    // Bus hold and release sequence
    always @* begin
        bus_next = bus_reg;
        cnt_next = cnt_reg;
        case (bus_reg)
            BUS_RUN: begin
                if (br_req & (end_s3 | frozen_reg)) begin
                    bus_next = BUS_WAITG;
                    cnt_next = HANDOVER_LAST;
                end
            end
            BUS_WAITG: begin
                if (cnt_reg == {`DPB_CNT_W{1'b0}}) begin
                    bus_next = BUS_GRANT;
                end else begin
                    cnt_next = cnt_reg - 1'b1;
                end
            end
            BUS_GRANT: begin
                if (!br_req) begin
                    bus_next = BUS_RETURN;
                    cnt_next = HANDOVER_LAST;
                end
            end
            BUS_RETURN: begin
                if (cnt_reg == {`DPB_CNT_W{1'b0}}) begin
                    bus_next = BUS_RUN;
                end else begin
                    cnt_next = cnt_reg - 1'b1;
                end
            end
            default: begin
                bus_next = BUS_RUN;
                cnt_next = {`DPB_CNT_W{1'b0}};
            end
        endcase
    end

    wire floating_next = (bus_next == BUS_GRANT) | (bus_next == BUS_RETURN & cnt_next != 0)
                         | (bus_reg == BUS_RETURN & cnt_reg != 0);
    wire rd_next = cur_valid_reg & ~cur_write_reg & ~freeze_next & |(phase_next & `DPB_RD_MASK);
    wire wr_next = cur_valid_reg & cur_write_reg & ~freeze_next & |(phase_next & `DPB_WR_MASK);
    wire wd_next = cur_valid_reg & cur_write_reg & ~freeze_next
                   & |(phase_next & `DPB_WDATA_MASK);

    // During reset the grant pin follows the request pin directly
    assign bus_grant_n = rs_n ? grant_n_reg : bus_request_n;

    always @(posedge clk or negedge rs_n) begin
        if (!rs_n) begin
            phase_reg      <= `DPB_PHASE_RESET;
            frozen_reg     <= 1'b0;
            bus_reg        <= BUS_RUN;
            cnt_reg        <= {`DPB_CNT_W{1'b0}};
            grant_n_reg    <= 1'b1;
            halt_pend_reg  <= 1'b0;
            halt_defer_reg <= 1'b0;
            trapped_reg    <= 1'b0;
            cur_valid_reg  <= 1'b0;
            cur_write_reg  <= 1'b0;
            cur_data_reg   <= 1'b0;
        end else begin
            phase_reg   <= phase_next;
            frozen_reg  <= freeze_next;
            bus_reg     <= bus_next;
            cnt_reg     <= cnt_next;
            grant_n_reg <= ~((bus_next == BUS_GRANT) | (bus_next == BUS_RETURN));
            if (end_s3 & halt_req) begin
                halt_pend_reg <= 1'b1;
            end else if (frozen_reg & bus_own & ~halt_req & ~trapped_reg) begin
                halt_pend_reg <= 1'b0;
            end
            if (end_s8 & running & halt_pend_reg & cur_data_reg) begin
                halt_defer_reg <= 1'b1;
            end else if (frozen_reg) begin
                halt_defer_reg <= 1'b0;
            end
            if (end_s7 & running & trap_in) begin
                trapped_reg <= 1'b1;
            end else if (frozen_reg & halt_req) begin
                trapped_reg <= 1'b0;
            end
            if (end_s8 & ~freeze_next) begin
                cur_valid_reg <= acc_valid;
                cur_write_reg <= acc_write;
                cur_data_reg  <= acc_data_space;
            end else if (freeze_next) begin
                cur_valid_reg <= 1'b0;
            end
        end
    end

    // Registered pins and user-side outputs
    always @(posedge clk or negedge rs_n) begin
        if (!rs_n) begin
            cycle_clock_out      <= 1'b0;
            cycle_state          <= `DPB_PHASE_RESET;
            prog_addr_bus        <= `DPB_RESET_ADDR;
            prog_addr_oe         <= 1'b1;
            prog_data_space_flag <= 1'b0;
            prog_mem_select_n    <= 1'b1;
            prog_read_strobe_n   <= 1'b1;
            prog_write_strobe_n  <= 1'b1;
            prog_ctrl_oe         <= 1'b1;
            prog_data_out        <= {DW{1'b0}};
            prog_data_oe         <= 1'b0;
            data_if_oe           <= 1'b1;
            ack_sync             <= 1'b1;
            irq_latched          <= {IW{1'b1}};
            halted               <= 1'b0;
            trap_active          <= 1'b0;
            acc_taken            <= 1'b0;
            rd_data              <= {DW{1'b0}};
            rd_valid             <= 1'b0;
        end else begin
            cycle_clock_out <= ~|(phase_next & `DPB_CLKO_LOW_MASK);
            cycle_state     <= phase_next;
            ack_sync        <= ack_s;
            halted          <= freeze_next;
            trap_active     <= (end_s7 & running & trap_in) | (trapped_reg & ~(frozen_reg & halt_req));
            prog_addr_oe    <= ~floating_next;
            prog_ctrl_oe    <= ~floating_next;
            data_if_oe      <= ~floating_next;
            acc_taken       <= 1'b0;
            rd_valid        <= 1'b0;
            if (end_s7 & running) begin
                irq_latched <= irq_s;
            end
            if (end_s8 & ~freeze_next) begin
                acc_taken <= 1'b1;
                if (acc_valid) begin
                    prog_addr_bus        <= acc_addr;
                    prog_data_space_flag <= acc_data_space;
                    prog_mem_select_n    <= 1'b0;
                end else begin
                    prog_mem_select_n    <= 1'b1;
                    prog_data_space_flag <= 1'b0;
                end
                prog_data_out <= acc_wdata;
            end else if (freeze_next) begin
                prog_mem_select_n    <= 1'b1;
                prog_data_space_flag <= 1'b0;
            end
            prog_read_strobe_n  <= ~rd_next;
            prog_write_strobe_n <= ~(wr_next & ~rd_next);
            prog_data_oe        <= wd_next & ~floating_next;
            if (phase_reg[`DPB_S7_BIT] & running & cur_valid_reg & ~cur_write_reg) begin
                rd_data  <= prog_data_in;
                rd_valid <= 1'b1;
            end
        end
    end
endmodule // dpb_core

`default_nettype wire

// File: include/dpb_consts.vh
// Constants shared by the program bus interface design files
`ifndef DPB_CONSTS_VH
`define DPB_CONSTS_VH

`define DPB_ADDR_W           14
`define DPB_DATA_W           24
`define DPB_IRQ_W            4
`define DPB_STATES           8
`define DPB_MCLK_PER_CYCLE   4
`define DPB_STATES_PER_MCLK  2
`define DPB_HANDOVER_MCLK    4
`define DPB_HANDOVER_CYC     (`DPB_HANDOVER_MCLK * `DPB_STATES_PER_MCLK)
`define DPB_CNT_W            4
`define DPB_PHASE_RESET      8'h08
`define DPB_PHASE_S1         8'h01
`define DPB_PHASE_S8         8'h80
`define DPB_RD_MASK          8'h7C
`define DPB_WR_MASK          8'h38
`define DPB_WDATA_MASK       8'h7C
`define DPB_CLKO_LOW_MASK    8'h78
`define DPB_RESET_ADDR       14'h0004
`define DPB_S3_BIT           2
`define DPB_S7_BIT           6
`define DPB_S8_BIT           7

`endif

// File: core/dpb_sync2.v
// Two-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/1ps
`default_nettype none

module dpb_sync2 #(
    parameter W = 1,
    parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
    input  wire         clk,      // Master clock
    input  wire         rst_n,    // Asynchronous reset, active low
    input  wire [W-1:0] async_in, // Inputs of arbitrary phase
    output wire [W-1:0] sync_out  // Synchronised copy
);
    reg [W-1:0] meta_reg;
    reg [W-1:0] sync_reg;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= RST_VAL;
            sync_reg <= RST_VAL;
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    assign sync_out = sync_reg;
endmodule // dpb_sync2

`default_nettype wire

// File: verification/dpb_core_props.sv
// Assertion checker for the program bus interface core
`timescale 1ns/1ps
`default_nettype none
`include "dpb_consts.vh"
module dpb_core_props #(
    parameter AW = 14
) (
    input wire logic          clk,                  // Master clock
    input wire logic          rst_n,                // Reset pin
    input wire logic          halt_n,               // Halt pin
    input wire logic          bus_request_n,        // Request pin
    input wire logic          bus_grant_n,          // Grant pin
    input wire logic          cycle_clock_out,      // Cycle clock
    input wire logic [7:0]    cycle_state,          // One-hot state
    input wire logic [AW-1:0] prog_addr_bus,        // Address
    input wire logic          prog_addr_oe,         // Address enable
    input wire logic          prog_data_space_flag, // Data-space flag
    input wire logic          prog_mem_select_n,    // Select
    input wire logic          prog_read_strobe_n,   // Read strobe
    input wire logic          prog_write_strobe_n,  // Write strobe
    input wire logic          prog_ctrl_oe,         // Control enable
    input wire logic          prog_data_oe,         // Data enable
    input wire logic          data_if_oe            // Data memory enable
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Request held long enough to be synchronised, seen at the end of state 3
    sequence req_seen;
        cycle_state[2] && bus_grant_n && !bus_request_n && !$past(bus_request_n)
            && !$past(bus_request_n, 2);
    endsequence
    sequence rel_seen;
        $rose(bus_request_n) && !bus_grant_n ##1 bus_request_n [*2];
    endsequence

    a_state_onehot: assert property ($onehot(cycle_state))
        else $error("state vector not one-hot");
    a_clock_phase: assert property (cycle_clock_out == !(|(cycle_state & `DPB_CLKO_LOW_MASK)))
        else $error("cycle clock out of phase with states");
    a_grant_floats: assert property (!bus_grant_n |-> !(prog_addr_oe || prog_ctrl_oe
                                     || prog_data_oe || data_if_oe))
        else $error("bus driven while granted");
    a_grant_latency: assert property (req_seen ##1 (!bus_request_n) [*8] |-> ##[1:3] !bus_grant_n)
        else $error("grant not given on time");
    a_grant_release: assert property (rel_seen |-> (!bus_grant_n) [*5] ##[1:6] bus_grant_n)
        else $error("grant not dropped on time");
    a_resume_state: assert property ($rose(bus_grant_n) && $past(rst_n) && halt_n && $past(halt_n)
        && $past(halt_n, 2) |-> cycle_state[7] ##1 cycle_state[0])
        else $error("no resume at state 1 after release");
    a_strobe_excl: assert property (prog_read_strobe_n || prog_write_strobe_n)
        else $error("both strobes active");
    a_read_window: assert property (!prog_read_strobe_n |-> |(cycle_state & `DPB_RD_MASK)
                                    && !prog_mem_select_n && prog_ctrl_oe)
        else $error("read strobe outside its window");
    a_write_window: assert property (!prog_write_strobe_n |-> |(cycle_state & `DPB_WR_MASK)
                                     && prog_data_oe && !prog_mem_select_n)
        else $error("write strobe outside its window");
    a_addr_steady: assert property (prog_ctrl_oe && !prog_mem_select_n && !cycle_state[7]
        |=> $stable(prog_addr_bus) && $stable(prog_data_space_flag))
        else $error("address or flag moved within a cycle");
endmodule // dpb_core_props

bind dpb_core dpb_core_props #(.AW(AW)) u_props (
    .clk, .rst_n, .halt_n, .bus_request_n, .bus_grant_n, .cycle_clock_out, .cycle_state,
    .prog_addr_bus, .prog_addr_oe, .prog_data_space_flag, .prog_mem_select_n,
    .prog_read_strobe_n, .prog_write_strobe_n, .prog_ctrl_oe, .prog_data_oe, .data_if_oe
);
`default_nettype wire

// File: verification/dpb_prog_mem.sv
// Behavioural program memory on the far side of the program bus
`timescale 1ns/1ps
`default_nettype none
module dpb_prog_mem (
    input  wire logic        clk,    // Master clock
    input  wire logic        slow,   // Late read data when set
    input  wire logic [13:0] addr,   // Address lines
    input  wire logic        dsf,    // Data-space flag
    input  wire logic        sel_n,  // Select
    input  wire logic        rd_n,   // Read strobe
    input  wire logic        wr_n,   // Write strobe
    input  wire logic        ctl_oe, // Control lines driven
    input  wire logic [23:0] dout,   // Data driven by the core
    input  wire logic        d_oe,   // Core drives data
    output var  logic [23:0] din     // Resolved data bus level
);
    logic [23:0] mem [0:32767];
    logic [23:0] last = 24'h00_0000;
    logic [2:0]  age = 3'h0;
    wire         rd_ok = ctl_oe && !sel_n && !rd_n && (!slow || age >= 3'h3);

    initial for (int i = 0; i < 32768; i++) mem[i] = {9'h1A5, 15'(i)};
    // A floating bus shows a changing pattern so stale data never passes
    assign din = d_oe ? dout : (rd_ok ? mem[{dsf, addr}] : ~last);
    always @(posedge clk) begin
        last <= din;
        age <= rd_n ? 3'h0 : (age == 3'h7 ? age : age + 3'h1);
        if (!wr_n && ctl_oe && !sel_n) mem[{dsf, addr}] <= dout;
    end
endmodule // dpb_prog_mem
`default_nettype wire

// File: verification/dsp_program_bus_interface_test.sv
// Self-checking testbench for the program bus interface core
`timescale 1ns/1ps
`default_nettype none
module dsp_program_bus_interface_test;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        halt_n = 1'b1;
    logic        bus_request_n = 1'b1;
    logic        ack = 1'b1;
    logic [3:0]  irq = 4'hF;
    logic        acc_valid = 1'b0;
    logic        acc_write = 1'b0;
    logic        acc_ds = 1'b0;
    logic        slow = 1'b0;
    logic [13:0] acc_addr = 14'h0000;
    logic [23:0] acc_wdata = 24'h00_0000;
    logic        bus_grant_n, clk_out, addr_oe, flag, sel_n, rd_n, wr_n, ctrl_oe, data_oe;
    logic        dif_oe, ack_sync, halted, acc_taken, rd_valid;
    logic [7:0]  cycle_state;
    logic [3:0]  irq_latched;
    logic [13:0] addr;
    logic [23:0] pdin, pdout, rd_data;
    int          miscompares = 0;
    int          n_compared = 0;
    logic [23:0] exp_q[$];
    logic [23:0] shadow[int];
    int          i;
    logic [13:0] a;

    dpb_core dut_u (.clk(clk), .rst_n(rst_n), .halt_n(halt_n), .bus_request_n(bus_request_n),
        .bus_grant_n(bus_grant_n), .data_mem_acknowledge(ack), .interrupt_requests(irq),
        .cycle_clock_out(clk_out), .cycle_state(cycle_state), .prog_addr_bus(addr),
        .prog_addr_oe(addr_oe), .prog_data_space_flag(flag), .prog_mem_select_n(sel_n),
        .prog_read_strobe_n(rd_n), .prog_write_strobe_n(wr_n), .prog_ctrl_oe(ctrl_oe),
        .prog_data_in(pdin), .prog_data_out(pdout), .prog_data_oe(data_oe),
        .data_if_oe(dif_oe), .ack_sync(ack_sync), .irq_latched(irq_latched), .halted(halted),
        .trap_active(), .trap_in(1'b0), .acc_valid(acc_valid), .acc_write(acc_write),
        .acc_data_space(acc_ds), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
        .acc_taken(acc_taken), .rd_data(rd_data), .rd_valid(rd_valid));
    dpb_prog_mem mem_u (.clk(clk), .slow(slow), .addr(addr), .dsf(flag), .sel_n(sel_n),
        .rd_n(rd_n), .wr_n(wr_n), .ctl_oe(ctrl_oe), .dout(pdout), .d_oe(data_oe), .din(pdin));

    always #25 clk = ~clk;

    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict;
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic wait_for(ref logic s, input logic v);
        int k;
        for (k = 0; k < 300 && s !== v; k++) @(posedge clk);
        if (k == 300) begin
            miscompares++;
            print_verdict();
        end
    endtask
    function automatic logic [23:0] mem_word(input logic [14:0] x);
        return shadow.exists(x) ? shadow[x] : {9'h1A5, x};
    endfunction
    // One access held until the core takes it; reads leave a note for the monitor
    task automatic access(input logic w, input logic ds, input logic [13:0] ad,
                          input logic [23:0] d);
        @(negedge clk);
        acc_valid = 1'b1;
        acc_write = w;
        acc_ds = ds;
        acc_addr = ad;
        acc_wdata = d;
        wait_for(acc_taken, 1'b1);
        if (w) shadow[int'({ds, ad})] = d;
        else exp_q.push_back(mem_word({ds, ad}));
        @(negedge clk);
        acc_valid = 1'b0;
    endtask

    always @(posedge clk) begin
        if (rd_valid === 1'b1) begin
            if (exp_q.size() > 0) chk(rd_data, exp_q.pop_front());
            else chk(24'(exp_q.size()), 24'h00_0001);
        end
    end

    initial begin
        void'($urandom(19));
        repeat (3) @(negedge clk);
        bus_request_n = 1'b0;
        #5 chk(bus_grant_n, 1'b0);
        repeat (3) @(negedge clk);
        bus_request_n = 1'b1;
        #5 chk(bus_grant_n, 1'b1);
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        $display("test reset grant done");
        for (i = 0; i < 10; i++) begin
            a = (i == 0) ? 14'h3FFF : 14'($urandom);
            slow = i[0];
            access(1'b1, i[1], a, 24'($urandom));
            access(1'b0, i[1], a, 24'h00_0000);
            access(1'b0, ~i[1], a, 24'h00_0000);
        end
        $display("test program access done");
        for (i = 0; i < 4; i++) begin
            wait_for(clk_out, 1'b1);
            @(negedge clk);
            irq = 4'($urandom);
            ack = 1'($urandom);
            wait_for(clk_out, 1'b0);
            wait_for(clk_out, 1'b1);
            chk(irq_latched, irq);
            chk(ack_sync, ack);
        end
        $display("test input sync done");
        @(negedge clk);
        ack = 1'b1;
        bus_request_n = 1'b0;
        wait_for(bus_grant_n, 1'b0);
        chk({addr_oe, ctrl_oe, data_oe, dif_oe}, 24'h00_0000);
        @(negedge clk);
        acc_valid = 1'b1;
        acc_write = 1'b0;
        acc_addr = 14'h0123;
        repeat (10) begin
            @(posedge clk);
            chk(acc_taken, 1'b0);
        end
        @(negedge clk);
        bus_request_n = 1'b1;
        access(1'b0, 1'b0, 14'h0123, 24'h00_0000);
        $display("test bus hold done");
        halt_n = 1'b0;
        wait_for(halted, 1'b1);
        chk(cycle_state, 8'h80);
        chk(sel_n, 1'b1);
        @(negedge clk);
        bus_request_n = 1'b0;
        wait_for(bus_grant_n, 1'b0);
        chk(halted, 1'b1);
        @(negedge clk);
        bus_request_n = 1'b1;
        wait_for(bus_grant_n, 1'b1);
        repeat (3) @(posedge clk);
        chk({halted, cycle_state}, 24'h00_0180);
        @(negedge clk);
        halt_n = 1'b1;
        wait_for(halted, 1'b0);
        access(1'b0, 1'b1, 14'h3FFF, 24'h00_0000);
        repeat (20) @(posedge clk);
        chk(24'(exp_q.size()), 24'h00_0000);
        $display("test halt and grant done");
        print_verdict();
    end
endmodule // dsp_program_bus_interface_test
`default_nettype wire
